// >>> include/sbm_pkg.sv
// sbm_pkg: shared constants for the dual-memory pin control block.
// assumes sv-2012 tools; nothing imported, users write sbm_pkg::name.
`default_nettype none
package sbm_pkg;
  localparam int          DATA_W          = 16;
  localparam int          ADDR_W          = 22;
  localparam int          ADDR_SEL_BIT    = 19;
  localparam int          LANE_W          = 8;
  localparam int          EXT_W           = 16;
  localparam int          PD_PERMIT_BIT   = 15;
  localparam int          PD_POLARITY_BIT = 14;
  // default setup words (plain values, no figure given)
  localparam logic [15:0] EXT_RESET       = 16'h0000;
  localparam logic [15:0] REFRESH_RESET   = 16'h0000;
  localparam logic [15:0] BUS_SETUP_RESET = 16'h0000;
  // refresh setup bit that selects deep power-down on deselect
  localparam int          REFRESH_DPD_BIT = 4;
  localparam int          NUM_BLOCKS      = 8;
  localparam int          BLK_W           = 3;
  localparam int          BLK_LSB         = 16;

  typedef enum logic [2:0] {
    SBM_F_RESET   = 3'b000,
    SBM_F_STANDBY = 3'b001,
    SBM_F_ACTIVE  = 3'b010,
    SBM_F_PDOWN   = 3'b011
  } sbm_flash_state_t;

  typedef enum logic [1:0] {
    SBM_P_STANDBY = 2'b00,
    SBM_P_PDOWN   = 2'b01,
    SBM_P_ACTIVE  = 2'b10
  } sbm_psram_state_t;

  // flash command codes (arbitrary, command set outside this block)
  localparam logic [15:0] CMD_LOCK        = 16'h0001;
  localparam logic [15:0] CMD_UNLOCK      = 16'h0002;
  localparam logic [15:0] CMD_LOCKDOWN    = 16'h0003;
  localparam logic [15:0] CMD_EXT_WRITE   = 16'h0004;
endpackage
`default_nettype wire

// >>> verilog/sbm_psram_ctl.sv
// sbm_psram_ctl: psram pin decode, byte lanes, setup registers.
// assumes strobes already synchronous to sys_clk and reset synchronised.
`default_nettype none
module sbm_psram_ctl (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_b,
  input  wire logic                      psram_chip_enable_n,
  input  wire logic                      psram_write_enable_n,
  input  wire logic                      psram_output_enable_n,
  input  wire logic                      psram_upper_byte_enable_n,
  input  wire logic                      psram_lower_byte_enable_n,
  input  wire logic                      psram_config_reg_select,
  input  wire logic [sbm_pkg::ADDR_W-1:0] addr,
  input  wire logic [sbm_pkg::DATA_W-1:0] dq_in,
  output logic [sbm_pkg::DATA_W-1:0]      dq_out,
  output logic [1:0]                     lane_oe_n,
  output logic [1:0]                     lane_wr,
  output logic                           active,
  output logic                           deep_power_down
);
  logic [15:0] psram_refresh_setup_reg;
  logic [15:0] psram_bus_setup_reg;
  logic [1:0]  lane_en;
  logic        sel;
  logic        wr_mode;
  logic        rd_mode;
  logic        cr_hit;

  assign sel     = !psram_chip_enable_n;
  assign lane_en = {!psram_upper_byte_enable_n, !psram_lower_byte_enable_n};
  assign wr_mode = sel && !psram_write_enable_n;
  assign rd_mode = sel && psram_write_enable_n && !psram_output_enable_n;
  assign cr_hit  = psram_config_reg_select;

  // deselect picks standby or deep power-down from the refresh setup
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      active          <= 1'b0;
      deep_power_down <= 1'b0;
    end else begin
      active          <= sel;
      deep_power_down <= !sel && psram_refresh_setup_reg[sbm_pkg::REFRESH_DPD_BIT];
    end
  end

  // setup register writes, selected by the address select bit
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      psram_refresh_setup_reg <= sbm_pkg::REFRESH_RESET;
      psram_bus_setup_reg     <= sbm_pkg::BUS_SETUP_RESET;
    end else if (wr_mode && cr_hit && (lane_en != 2'b00)) begin
      if (addr[sbm_pkg::ADDR_SEL_BIT])
        psram_bus_setup_reg <= dq_in;
      else
        psram_refresh_setup_reg <= dq_in;
    end
  end

  // array writes leave through lane_wr; lanes gated per byte
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lane_wr   <= 2'b00;
      lane_oe_n <= 2'b11;
      dq_out    <= 16'h0000;
    end else begin
      lane_wr   <= (wr_mode && !cr_hit) ? lane_en : 2'b00;
      lane_oe_n <= rd_mode ? ~lane_en : 2'b11;
      if (rd_mode && cr_hit)
        dq_out <= addr[sbm_pkg::ADDR_SEL_BIT] ? psram_bus_setup_reg
                                              : psram_refresh_setup_reg;
      else
        dq_out <= dq_in;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/sbm_pin_ctl.sv
// sbm_pin_ctl: top of the shared-bus dual memory pin control.
// assumes host pins synchronous to sys_clk; data pins split into in/out/oe.
`default_nettype none
// Summary of operation
// - flash chip select high deselects, floats outputs, standby; low active
// - flash output enable gates flash read data onto bus
// - flash write captured on first rising edge of select or strobe
// - write protect low: locked-down blocks cannot change protection
// - write protect high: locked-down blocks accept lock and unlock
// - flash reset low: reset mode, outputs float, low current
// - hardware reset locks every block and restores extended setup
// - leaving reset the flash reads asynchronously
// - psram deselect enters standby or deep power-down per refresh setup
// - psram write strobe low puts psram in write mode
// - psram output enable low enables psram reads
// - upper byte enable gates upper data lanes
// - lower byte enable gates lower data lanes
// - both byte enables high: psram neither drives nor accepts data
// - both byte enables high: psram stays active while selected
// - config select high targets refresh or bus setup by address bit
// - power-down only from standby with permit bit set
// - in deep power-down no contents change
// - power-down polarity follows polarity bit, default active low
module sbm_pin_ctl (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_b,
  input  wire logic                      flash_chip_enable_n,
  input  wire logic                      flash_output_enable_n,
  input  wire logic                      flash_write_enable_n,
  input  wire logic                      flash_write_protect_n,
  input  wire logic                      flash_reset_n,
  input  wire logic                      flash_power_down_input,
  input  wire logic                      latch_enable_n,
  input  wire logic                      psram_chip_enable_n,
  input  wire logic                      psram_write_enable_n,
  input  wire logic                      psram_output_enable_n,
  input  wire logic                      psram_upper_byte_enable_n,
  input  wire logic                      psram_lower_byte_enable_n,
  input  wire logic                      psram_config_reg_select,
  input  wire logic [sbm_pkg::ADDR_W-1:0] addr,
  input  wire logic [sbm_pkg::DATA_W-1:0] dq_in,
  output logic [sbm_pkg::DATA_W-1:0]      dq_out,
  output logic [1:0]                     dq_oe_n,
  output logic [sbm_pkg::NUM_BLOCKS-1:0] block_locked,
  output logic [sbm_pkg::NUM_BLOCKS-1:0] block_locked_down,
  output logic [15:0]                    flash_extended_setup_reg,
  output logic                           flash_active,
  output logic                           flash_standby,
  output logic                           flash_in_reset,
  output logic                           flash_deep_power_down,
  output logic                           flash_async_read,
  output logic                           flash_read_valid,
  output logic                           flash_write_strobe,
  output logic [sbm_pkg::ADDR_W-1:0]     flash_write_addr,
  output logic [sbm_pkg::DATA_W-1:0]     flash_write_data,
  output logic [1:0]                     psram_lane_write,
  output logic                           psram_active,
  output logic                           psram_deep_power_down
);
  logic                      rst_meta;
  logic                      rst_sync;
  sbm_pkg::sbm_flash_state_t state;
  sbm_pkg::sbm_flash_state_t next_state;
  logic                      f_sel_q;
  logic                      f_we_q;
  logic                      lat_q;
  logic                      f_wr_cycle;
  logic [sbm_pkg::ADDR_W-1:0] cap_addr;
  logic [sbm_pkg::DATA_W-1:0] cap_data;
  logic                      pd_asserted;
  logic                      f_sel;
  logic                      f_end;
  logic [sbm_pkg::DATA_W-1:0] p_dq;
  logic [1:0]                p_oe_n;
  logic                      p_act;
  logic                      p_dpd;
  logic [sbm_pkg::BLK_W-1:0] blk;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  function automatic logic pd_active(input logic pin, input logic [15:0] ext);
    // polarity bit set means active high; default zero is active low
    pd_active = ext[sbm_pkg::PD_POLARITY_BIT] ? pin : !pin;
  endfunction

  assign pd_asserted = pd_active(flash_power_down_input, flash_extended_setup_reg);
  assign f_sel       = !flash_chip_enable_n && flash_reset_n;
  // write ends at whichever strobe rises first
  assign f_end       = f_wr_cycle && (flash_chip_enable_n || flash_write_enable_n);
  assign blk         = cap_addr[sbm_pkg::BLK_LSB +: sbm_pkg::BLK_W];

  always_comb begin
    next_state = state;
    unique case (state)
      sbm_pkg::SBM_F_RESET:
        next_state = flash_reset_n ? sbm_pkg::SBM_F_STANDBY : sbm_pkg::SBM_F_RESET;
      sbm_pkg::SBM_F_STANDBY: begin
        if (!flash_reset_n)
          next_state = sbm_pkg::SBM_F_RESET;
        else if (pd_asserted && flash_extended_setup_reg[sbm_pkg::PD_PERMIT_BIT])
          next_state = sbm_pkg::SBM_F_PDOWN;
        else if (!flash_chip_enable_n)
          next_state = sbm_pkg::SBM_F_ACTIVE;
      end
      sbm_pkg::SBM_F_ACTIVE: begin
        if (!flash_reset_n)
          next_state = sbm_pkg::SBM_F_RESET;
        else if (flash_chip_enable_n)
          next_state = sbm_pkg::SBM_F_STANDBY;
      end
      sbm_pkg::SBM_F_PDOWN: begin
        if (!flash_reset_n)
          next_state = sbm_pkg::SBM_F_RESET;
        else if (!pd_asserted)
          next_state = sbm_pkg::SBM_F_STANDBY;
      end
      default: next_state = sbm_pkg::SBM_F_RESET;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync)
      state <= sbm_pkg::SBM_F_RESET;
    else
      state <= next_state;
  end

  // mode flags straight from flops
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      flash_active          <= 1'b0;
      flash_standby         <= 1'b0;
      flash_in_reset        <= 1'b1;
      flash_deep_power_down <= 1'b0;
    end else begin
      flash_active          <= next_state == sbm_pkg::SBM_F_ACTIVE;
      flash_standby         <= next_state == sbm_pkg::SBM_F_STANDBY;
      flash_in_reset        <= next_state == sbm_pkg::SBM_F_RESET;
      flash_deep_power_down <= next_state == sbm_pkg::SBM_F_PDOWN;
    end
  end

  // async read after reset; data trusted only after select/latch fall
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      flash_async_read <= 1'b1;
      flash_read_valid <= 1'b0;
      f_sel_q          <= 1'b1;
      lat_q            <= 1'b1;
    end else begin
      f_sel_q <= flash_chip_enable_n;
      lat_q   <= latch_enable_n;
      if (!flash_reset_n) begin
        flash_async_read <= 1'b1;
        flash_read_valid <= 1'b0;
      end else if ((f_sel_q && !flash_chip_enable_n) || (lat_q && !latch_enable_n))
        flash_read_valid <= 1'b1;
    end
  end

  // write capture window: opens when both low, closes on first rise
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      f_wr_cycle <= 1'b0;
      f_we_q     <= 1'b1;
      cap_addr   <= '0;
      cap_data   <= '0;
    end else begin
      f_we_q <= flash_write_enable_n;
      if (f_sel && !flash_write_enable_n && flash_output_enable_n &&
          state != sbm_pkg::SBM_F_PDOWN) begin
        f_wr_cycle <= 1'b1;
        cap_addr   <= addr;
        cap_data   <= dq_in;
      end else begin
        f_wr_cycle <= 1'b0;
      end
    end
  end

  // write strobe out on closing edge
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      flash_write_strobe <= 1'b0;
      flash_write_addr   <= '0;
      flash_write_data   <= '0;
    end else begin
      flash_write_strobe <= f_end && !flash_deep_power_down;
      if (f_end) begin
        flash_write_addr <= cap_addr;
        flash_write_data <= cap_data;
      end
    end
  end

  // block protection, extended setup; hardware reset relocks all
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      block_locked             <= '1;
      block_locked_down        <= '0;
      flash_extended_setup_reg <= sbm_pkg::EXT_RESET;
    end else if (!flash_reset_n) begin
      block_locked             <= '1;
      block_locked_down        <= '0;
      flash_extended_setup_reg <= sbm_pkg::EXT_RESET;
    end else if (f_end && !flash_deep_power_down) begin
      unique case (cap_data)
        sbm_pkg::CMD_LOCK:
          if (flash_write_protect_n || !block_locked_down[blk])
            block_locked[blk] <= 1'b1;
        sbm_pkg::CMD_UNLOCK:
          if (flash_write_protect_n || !block_locked_down[blk])
            block_locked[blk] <= 1'b0;
        sbm_pkg::CMD_LOCKDOWN:
          block_locked_down[blk] <= 1'b1;
        sbm_pkg::CMD_EXT_WRITE:
          flash_extended_setup_reg <= cap_addr[15:0];
        default: ;
      endcase
    end
  end

  sbm_psram_ctl u_psram (
    .sys_clk                   (sys_clk),
    .rst_b                     (rst_sync),
    .psram_chip_enable_n       (psram_chip_enable_n),
    .psram_write_enable_n      (psram_write_enable_n),
    .psram_output_enable_n     (psram_output_enable_n),
    .psram_upper_byte_enable_n (psram_upper_byte_enable_n),
    .psram_lower_byte_enable_n (psram_lower_byte_enable_n),
    .psram_config_reg_select   (psram_config_reg_select),
    .addr                      (addr),
    .dq_in                     (dq_in),
    .dq_out                    (p_dq),
    .lane_oe_n                 (p_oe_n),
    .lane_wr                   (psram_lane_write),
    .active                    (p_act),
    .deep_power_down           (p_dpd)
  );

  // bus drive; flash owns it only when selected, out of reset, oe low.
  // host keeps one component off, so no arbitration here
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      dq_oe_n               <= 2'b11;
      dq_out                <= '0;
      psram_active          <= 1'b0;
      psram_deep_power_down <= 1'b0;
    end else begin
      psram_active          <= p_act;
      psram_deep_power_down <= p_dpd;
      if (f_sel && !flash_output_enable_n && flash_write_enable_n) begin
        dq_oe_n <= 2'b00;
        dq_out  <= {cap_addr[7:0], cap_data[7:0]};
      end else begin
        dq_oe_n <= p_oe_n;
        dq_out  <= p_dq;
      end
    end
  end

  property p_excl;
    @(posedge sys_clk) disable iff (!rst_sync)
      !(!flash_chip_enable_n && !psram_chip_enable_n);
  endproperty
  a_excl: assert property (p_excl) else $error("both chip selects low");

  property p_float_reset;
    @(posedge sys_clk) disable iff (!rst_sync)
      !flash_reset_n && psram_chip_enable_n |=> dq_oe_n == 2'b11;
  endproperty
  a_float_reset: assert property (p_float_reset) else $error("drive in reset");

  property p_relock;
    @(posedge sys_clk) disable iff (!rst_sync)
      !flash_reset_n |=> block_locked == '1 && flash_extended_setup_reg == sbm_pkg::EXT_RESET;
  endproperty
  a_relock: assert property (p_relock) else $error("reset did not relock");

  property p_pd_gate;
    @(posedge sys_clk) disable iff (!rst_sync)
      $rose(flash_deep_power_down) |-> $past(flash_extended_setup_reg[15]);
  endproperty
  a_pd_gate: assert property (p_pd_gate) else $error("power-down without permit");

  property p_pd_nowrite;
    @(posedge sys_clk) disable iff (!rst_sync)
      flash_deep_power_down |=> !flash_write_strobe;
  endproperty
  a_pd_nowrite: assert property (p_pd_nowrite) else $error("write in power-down");

  property p_deselect;
    @(posedge sys_clk) disable iff (!rst_sync)
      flash_chip_enable_n && psram_chip_enable_n ##1 flash_chip_enable_n
        |-> !flash_active;
  endproperty
  a_deselect: assert property (p_deselect) else $error("flash active while deselected");

  property p_lanes_off;
    @(posedge sys_clk) disable iff (!rst_sync)
      // held two cycles: the bus enable runs two flops behind the pins
      psram_upper_byte_enable_n && psram_lower_byte_enable_n && flash_chip_enable_n
        ##1 psram_upper_byte_enable_n && psram_lower_byte_enable_n && flash_chip_enable_n
        |=> dq_oe_n == 2'b11 && psram_lane_write == 2'b00;
  endproperty
  a_lanes_off: assert property (p_lanes_off) else $error("psram lanes live");

  property p_psram_act;
    @(posedge sys_clk) disable iff (!rst_sync)
      !psram_chip_enable_n ##1 !psram_chip_enable_n |=> psram_active;
  endproperty
  a_psram_act: assert property (p_psram_act) else $error("psram not active");

  c_write: cover property (@(posedge sys_clk) disable iff (!rst_sync) flash_write_strobe);
  c_pdown: cover property (@(posedge sys_clk) disable iff (!rst_sync) flash_deep_power_down);
  c_pread: cover property (@(posedge sys_clk) disable iff (!rst_sync) dq_oe_n == 2'b10);
endmodule
`default_nettype wire

// >>> verif/sbm_host_model.sv
// sbm_host_model: host controller that drives the shared flash/psram pins.
// assumes the bench calls its tasks; pins move only at sys_clk rising edges.
`default_nettype none
module sbm_host_model (
  input  wire logic                       sys_clk,
  output var logic                        flash_chip_enable_n,
  output var logic                        flash_output_enable_n,
  output var logic                        flash_write_enable_n,
  output var logic                        flash_write_protect_n,
  output var logic                        flash_reset_n,
  output var logic                        flash_power_down_input,
  output var logic                        latch_enable_n,
  output var logic                        psram_chip_enable_n,
  output var logic                        psram_write_enable_n,
  output var logic                        psram_output_enable_n,
  output var logic                        psram_upper_byte_enable_n,
  output var logic                        psram_lower_byte_enable_n,
  output var logic                        psram_config_reg_select,
  output var logic [sbm_pkg::ADDR_W-1:0]  addr,
  output var logic [sbm_pkg::DATA_W-1:0]  host_data,
  output var logic                        host_drive
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {flash_write_protect_n, flash_reset_n, flash_power_down_input, latch_enable_n} = 4'hf;
    {flash_chip_enable_n, flash_output_enable_n, flash_write_enable_n} = 3'h7;
    {psram_chip_enable_n, psram_write_enable_n, psram_output_enable_n} = 3'h7;
    {psram_upper_byte_enable_n, psram_lower_byte_enable_n, psram_config_reg_select} = 3'h6;
    {addr, host_data, host_drive} = '0;
  end
  // both selects high and bus released
  task automatic idle();
    @(posedge sys_clk);
    {flash_chip_enable_n, flash_output_enable_n, flash_write_enable_n} <= 3'h7;
    {psram_chip_enable_n, psram_write_enable_n, psram_output_enable_n} <= 3'h7;
    {psram_upper_byte_enable_n, psram_lower_byte_enable_n, psram_config_reg_select} <= 3'h6;
    host_drive <= 1'b0;
  endtask
  task automatic set_pins(input logic wp_n, input logic rst_n, input logic pd);
    @(posedge sys_clk);
    {flash_write_protect_n, flash_reset_n, flash_power_down_input} <= {wp_n, rst_n, pd};
  endtask
  // psram held off while flash selected bus moves as the window closes
  task automatic fwrite(input logic [sbm_pkg::ADDR_W-1:0] a,
                        input logic [sbm_pkg::DATA_W-1:0] d, input logic we_first);
    @(posedge sys_clk);
    psram_chip_enable_n <= 1'b1;
    {flash_chip_enable_n, flash_output_enable_n, flash_write_enable_n} <= 3'h2;
    {addr, host_data, host_drive} <= {a, d, 1'b1};
    @(posedge sys_clk);
    {flash_chip_enable_n, flash_write_enable_n} <= {~we_first, 1'b1};
    {addr, host_data} <= {~a, ~d};
    @(posedge sys_clk);
    {flash_chip_enable_n, host_drive} <= 2'h2;
  endtask
  // select falls before read data is trusted; bus released
  task automatic fread();
    @(posedge sys_clk);
    psram_chip_enable_n <= 1'b1;
    {flash_chip_enable_n, flash_output_enable_n, flash_write_enable_n, host_drive} <= 4'h2;
  endtask
  // flash deselected so it floats while psram owns the bus
  task automatic pcycle(input logic we_n, input logic oe_n, input logic cr,
                        input logic [1:0] be, input logic [sbm_pkg::ADDR_W-1:0] a,
                        input logic [sbm_pkg::DATA_W-1:0] d);
    @(posedge sys_clk);
    flash_chip_enable_n <= 1'b1;
    {psram_chip_enable_n, psram_write_enable_n, psram_output_enable_n} <= {1'b0, we_n, oe_n};
    {psram_upper_byte_enable_n, psram_lower_byte_enable_n, psram_config_reg_select} <= {be, cr};
    {addr, host_data, host_drive} <= {a, d, ~we_n};
  endtask
endmodule
`default_nettype wire

// >>> verif/tb.sv
// tb: self-checking bench for the shared-bus dual memory pin control.
// assumes sbm_pkg compiled first; the host model drives every pin except sys_clk, rst_b and dq_in, which the bench drives.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int AW = sbm_pkg::ADDR_W;
  localparam int DW = sbm_pkg::DATA_W;
  localparam logic [4:0] WPS = 5'b10111;
  localparam logic [15:0] CMDS [5] = '{sbm_pkg::CMD_UNLOCK, sbm_pkg::CMD_LOCK,
    sbm_pkg::CMD_LOCKDOWN, sbm_pkg::CMD_UNLOCK, sbm_pkg::CMD_UNLOCK};
  logic          sys_clk, rst_b, flash_chip_enable_n, flash_output_enable_n;
  logic          flash_write_enable_n, flash_write_protect_n, flash_reset_n;
  logic          flash_power_down_input, latch_enable_n, psram_chip_enable_n;
  logic          psram_write_enable_n, psram_output_enable_n, psram_config_reg_select;
  logic          psram_upper_byte_enable_n, psram_lower_byte_enable_n, host_drive;
  logic          flash_active, flash_standby, flash_in_reset, flash_deep_power_down;
  logic          flash_async_read, flash_read_valid, flash_write_strobe;
  logic          psram_active, psram_deep_power_down;
  logic [1:0]    dq_oe_n, psram_lane_write, st, be;
  logic [7:0]    block_locked, block_locked_down;
  logic [15:0]   flash_extended_setup_reg;
  logic [AW-1:0] addr, flash_write_addr, a;
  logic [DW-1:0] dq_in, dq_out, host_data, flash_write_data, d;
  logic [DW-1:0] junk = 16'h5a5a;
  logic [2:0]    b;
  int            n_errors = 0;
  int            n_checks = 0;
  // released lanes flip each cycle so a stale value never looks valid
  always @(posedge sys_clk) junk <= ~junk;
  assign dq_in = host_drive ? host_data :
    {dq_oe_n[1] ? junk[15:8] : dq_out[15:8], dq_oe_n[0] ? junk[7:0] : dq_out[7:0]};
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  sbm_host_model host_u (.sys_clk, .flash_chip_enable_n, .flash_output_enable_n,
    .flash_write_enable_n, .flash_write_protect_n, .flash_reset_n, .flash_power_down_input,
    .latch_enable_n, .psram_chip_enable_n, .psram_write_enable_n, .psram_output_enable_n,
    .psram_upper_byte_enable_n, .psram_lower_byte_enable_n, .psram_config_reg_select,
    .addr, .host_data, .host_drive);
  sbm_pin_ctl dut_u (.sys_clk, .rst_b, .flash_chip_enable_n, .flash_output_enable_n,
    .flash_write_enable_n, .flash_write_protect_n, .flash_reset_n, .flash_power_down_input,
    .latch_enable_n, .psram_chip_enable_n, .psram_write_enable_n, .psram_output_enable_n,
    .psram_upper_byte_enable_n, .psram_lower_byte_enable_n, .psram_config_reg_select,
    .addr, .dq_in, .dq_out, .dq_oe_n, .block_locked, .block_locked_down,
    .flash_extended_setup_reg, .flash_active, .flash_standby, .flash_in_reset,
    .flash_deep_power_down, .flash_async_read, .flash_read_valid, .flash_write_strobe,
    .flash_write_addr, .flash_write_data, .psram_lane_write, .psram_active,
    .psram_deep_power_down);
  // st is {locked_down, locked}
  function automatic logic [1:0] lock_next(input logic [1:0] s, input logic [15:0] cmd,
                                           input logic wp_n);
    if (s[1] && !wp_n) return s;
    if (cmd == sbm_pkg::CMD_LOCK) return {s[1], 1'b1};
    if (cmd == sbm_pkg::CMD_UNLOCK) return {s[1], 1'b0};
    if (cmd == sbm_pkg::CMD_LOCKDOWN) return {1'b1, s[0]};
    return s;
  endfunction
  function automatic logic [1:0] psram_oe(input logic [1:0] ben, input logic oe_n);
    return oe_n ? 2'b11 : ben;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic pd_step(input logic [15:0] ext, input logic pd, input logic exp_pd);
    host_u.fwrite(AW'(ext), sbm_pkg::CMD_EXT_WRITE, 1'b0);
    host_u.set_pins(1'b1, 1'b1, pd);
    settle();
    chk({flash_extended_setup_reg, flash_deep_power_down}, {ext, exp_pd});
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    rst_b = 1'b0;
    void'($urandom(514));
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    settle();
    chk({block_locked, flash_async_read, flash_read_valid}, 10'h3fe);
    host_u.fread();
    settle();
    chk({dq_oe_n, flash_active, flash_read_valid}, 4'b0011);
    host_u.idle();
    settle();
    chk({dq_oe_n, flash_standby}, 3'b111);
    $display("test flash read done");
    for (int i = 0; i < 6; i++) begin
      a = AW'($urandom);
      d = {1'b1, 15'($urandom)}; // top bit keeps data clear of command codes
      host_u.fwrite(a, d, i[0]);
      #1;
      chk({flash_write_strobe, flash_write_addr}, {1'b1, a});
      chk(flash_write_data, d);
      @(posedge sys_clk);
      #1;
      chk(flash_write_strobe, 1'b0);
    end
    $display("test flash write done");
    b = 3'($urandom);
    st = 2'b01;
    for (int i = 0; i < 5; i++) begin
      host_u.set_pins(WPS[i], 1'b1, 1'b1);
      st = lock_next(st, CMDS[i], WPS[i]);
      host_u.fwrite(AW'(b) << sbm_pkg::BLK_LSB, CMDS[i], 1'b0);
      settle();
      chk({block_locked_down[b], block_locked[b]}, st);
    end
    $display("test lock done");
    pd_step(16'h8000, 1'b0, 1'b1);
    host_u.fwrite(a, d, 1'b0);
    #1;
    chk(flash_write_strobe, 1'b0);
    host_u.set_pins(1'b1, 1'b1, 1'b1);
    settle();
    chk(flash_deep_power_down, 1'b0);
    pd_step(16'hc000, 1'b1, 1'b1);
    host_u.set_pins(1'b1, 1'b1, 1'b0);
    settle();
    chk(flash_deep_power_down, 1'b0);
    pd_step(16'h4000, 1'b1, 1'b0);
    host_u.set_pins(1'b1, 1'b0, 1'b1);
    settle();
    chk({flash_in_reset, dq_oe_n, block_locked}, {1'b1, 2'b11, 8'hff});
    chk(flash_extended_setup_reg, sbm_pkg::EXT_RESET);
    host_u.set_pins(1'b1, 1'b1, 1'b1);
    settle();
    chk({flash_in_reset, flash_async_read, flash_read_valid}, 3'b010);
    $display("test power-down and reset done");
    for (int i = 0; i < 8; i++) begin
      host_u.pcycle(1'b1, i[2], 1'b0, i[1:0], AW'($urandom), 16'h0000);
      settle();
      chk({dq_oe_n, psram_lane_write, psram_active},
          {psram_oe(i[1:0], i[2]), 2'b00, 1'b1});
    end
    be = 2'($urandom);
    host_u.pcycle(1'b0, 1'b1, 1'b0, be, AW'($urandom), DW'($urandom));
    settle();
    chk(psram_lane_write, be ^ 2'b11);
    host_u.idle();
    settle();
    chk({psram_active, psram_deep_power_down}, 2'b00);
    host_u.pcycle(1'b0, 1'b1, 1'b1, 2'b00, AW'(0), 16'h0010);
    settle();
    chk(psram_lane_write, 2'b00);
    host_u.pcycle(1'b0, 1'b1, 1'b1, 2'b00, 22'h08_0000, 16'h0000);
    host_u.idle();
    settle();
    chk({psram_active, psram_deep_power_down}, 2'b01);
    $display("test psram done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
